// [eeprom_rd_pkg.sv]
package eeprom_rd_pkg;
    localparam int          ARRAY_BYTES    = 8192;
    localparam int          ARRAY_AW       = 13;
    localparam int          IDPAGE_BYTES   = 32;
    localparam int          IDPAGE_AW      = 5;
    localparam int          IDPAGE_OFS_HI  = 5;
    localparam logic [3:0]  TYPE_ARRAY     = 4'hA;
    localparam logic [3:0]  TYPE_IDPAGE    = 4'hB;
    localparam int          LOCK_SEL_BIT   = 10;
    localparam int          LOCK_DATA_BIT  = 1;
    localparam logic [3:0]  BIT_LAST       = 4'h7;
    localparam logic [3:0]  BIT_ACK        = 4'h8;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
    localparam int          SYNC_STAGES    = 2;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_WDATA,
        ST_READ
    } slave_state_e;
endpackage : eeprom_rd_pkg

// [pin_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser for asynchronous pin levels
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // bus idles high, so reset to all ones avoids a false start at release
    always_comb begin
        nxt_meta = i_sys_rst ? {WIDTH{1'b1}} : i_async;
        nxt_sync = i_sys_rst ? {WIDTH{1'b1}} : meta_ff;
    end

    always_ff @(posedge i_clk) begin
        meta_ff <= nxt_meta;
        sync_ff <= nxt_sync;
    end

    assign o_sync = sync_ff;
endmodule : pin_sync
`default_nettype wire

// [eeprom_rd_slave.sv]
`timescale 1ns/10ps
`default_nettype none
module eeprom_rd_slave
    import eeprom_rd_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic [2:0] i_chip_select_inputs,
    output logic            o_sda,
    output logic            o_sda_oe,
    output logic            o_idpage_locked
);
    import eeprom_rd_pkg::*;

    logic [4:0] sync_in;
    logic       scl;
    logic       sda;
    logic [2:0] cs_pins;

    pin_sync #(.WIDTH(5)) pin_sync_inst (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_scl, i_sda, i_chip_select_inputs}),
        .o_sync    (sync_in)
    );
    assign scl     = sync_in[4];
    assign sda     = sync_in[3];
    assign cs_pins = sync_in[2:0];

    logic scl_d_ff;
    logic sda_d_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    assign scl_rise   = scl & ~scl_d_ff;
    assign scl_fall   = ~scl & scl_d_ff;
    assign start_cond = scl & scl_d_ff & sda_d_ff & ~sda;
    assign stop_cond  = scl & scl_d_ff & ~sda_d_ff & sda;

    always_ff @(posedge i_clk) begin
        scl_d_ff <= i_sys_rst ? 1'b1 : scl;
        sda_d_ff <= i_sys_rst ? 1'b1 : sda;
    end

    // storage; array and id page are flip-flops indexed by address
    logic [7:0]          mem_ff    [ARRAY_BYTES];
    logic [7:0]          idmem_ff  [IDPAGE_BYTES];
    logic                lock_ff = 1'b0;

    slave_state_e        state_ff,  nxt_state;
    logic [3:0]          bit_ff,    nxt_bit;
    logic [7:0]          shift_ff,  nxt_shift;
    logic [ARRAY_AW-1:0] addr_ff,   nxt_addr;
    logic [7:0]          hi_ff,     nxt_hi;
    logic                idsel_ff,  nxt_idsel;
    logic                lockop_ff, nxt_lockop;
    logic                acking_ff, nxt_acking;
    logic                drive_ff,  nxt_drive;
    logic                sda_out_ff, nxt_sda_out;
    logic                wr_en;
    logic                lock_set;

    function automatic logic [7:0] rd_byte(
        input logic                idp,
        input logic [ARRAY_AW-1:0] a
    );
        // id page offset: bits 15..6 ignored, beyond 31 reads erased
        if (idp) begin
            rd_byte = a[IDPAGE_OFS_HI] ? ERASED_BYTE
                                       : idmem_ff[a[IDPAGE_AW-1:0]];
        end else begin
            rd_byte = mem_ff[a];
        end
    endfunction : rd_byte

    always_comb begin
        nxt_state   = state_ff;
        nxt_bit     = bit_ff;
        nxt_shift   = shift_ff;
        nxt_addr    = addr_ff;
        nxt_hi      = hi_ff;
        nxt_idsel   = idsel_ff;
        nxt_lockop  = lockop_ff;
        nxt_acking  = acking_ff;
        nxt_drive   = drive_ff;
        nxt_sda_out = sda_out_ff;
        wr_en       = 1'b0;
        lock_set    = 1'b0;
        if (stop_cond) begin
            nxt_state = ST_IDLE;
            nxt_drive = 1'b0;
        end else if (start_cond) begin
            nxt_state  = ST_DEV;
            nxt_bit    = 4'h0;
            nxt_drive  = 1'b0;
            nxt_acking = 1'b0;
        end else if (state_ff != ST_IDLE) begin
            if (scl_rise) begin
                if (acking_ff) begin
                    // controller ack slot after a byte we sent
                    if (state_ff == ST_READ && sda) begin
                        nxt_state = ST_IDLE;
                    end
                end else if (state_ff == ST_READ) begin
                    nxt_bit = bit_ff + 4'h1;
                end else begin
                    nxt_shift = {shift_ff[6:0], sda};
                    nxt_bit   = bit_ff + 4'h1;
                end
            end else if (scl_fall) begin
                if (acking_ff) begin
                    nxt_acking = 1'b0;
                    nxt_drive  = 1'b0;
                    nxt_bit    = 4'h0;
                    if (state_ff == ST_READ) begin
                        // next byte after our ack or controller ack
                        nxt_shift   = rd_byte(idsel_ff, addr_ff);
                        nxt_addr    = addr_ff + 1'b1;
                        nxt_drive   = ~nxt_shift[7];
                        nxt_sda_out = 1'b0;
                    end
                end else if (bit_ff == BIT_ACK && state_ff != ST_READ) begin
                    nxt_acking  = 1'b1;
                    nxt_sda_out = 1'b0;
                    nxt_drive   = 1'b1;
                    case (state_ff)
                        ST_DEV: begin
                            if (shift_ff[3:1] != cs_pins ||
                                (shift_ff[7:4] != TYPE_ARRAY &&
                                 shift_ff[7:4] != TYPE_IDPAGE)) begin
                                nxt_state  = ST_IDLE;
                                nxt_acking = 1'b0;
                                nxt_drive  = 1'b0;
                            end else begin
                                nxt_idsel = (shift_ff[7:4] == TYPE_IDPAGE);
                                nxt_state = shift_ff[0] ? ST_READ : ST_ADDR_HI;
                            end
                        end
                        ST_ADDR_HI: begin
                            nxt_hi    = shift_ff;
                            nxt_state = ST_ADDR_LO;
                        end
                        ST_ADDR_LO: begin
                            nxt_addr   = {hi_ff[ARRAY_AW-9:0], shift_ff};
                            nxt_lockop = idsel_ff & hi_ff[LOCK_SEL_BIT-8];
                            nxt_state  = ST_WDATA;
                        end
                        ST_WDATA: begin
                            if (lockop_ff) begin
                                lock_set = shift_ff[LOCK_DATA_BIT];
                            end else if (idsel_ff && lock_ff) begin
                                nxt_acking = 1'b0;
                                nxt_drive  = 1'b0;
                                nxt_state  = ST_IDLE;
                            end else begin
                                wr_en = 1'b1;
                                nxt_addr = idsel_ff
                                    ? {addr_ff[ARRAY_AW-1:IDPAGE_AW],
                                       addr_ff[IDPAGE_AW-1:0] + 1'b1}
                                    : addr_ff + 1'b1;
                            end
                        end
                        default: nxt_state = ST_IDLE;
                    endcase
                end else if (state_ff == ST_READ) begin
                    if (bit_ff == BIT_ACK) begin
                        // byte done; release for the controller ack slot
                        nxt_drive  = 1'b0;
                        nxt_acking = 1'b1;
                    end else begin
                        nxt_shift = {shift_ff[6:0], 1'b1};
                        nxt_drive = ~shift_ff[6];
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_ff   <= ST_IDLE;
            bit_ff     <= 4'h0;
            shift_ff   <= 8'h00;
            addr_ff    <= '0;
            hi_ff      <= 8'h00;
            idsel_ff   <= 1'b0;
            lockop_ff  <= 1'b0;
            acking_ff  <= 1'b0;
            drive_ff   <= 1'b0;
            sda_out_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            bit_ff     <= nxt_bit;
            shift_ff   <= nxt_shift;
            addr_ff    <= nxt_addr;
            hi_ff      <= nxt_hi;
            idsel_ff   <= nxt_idsel;
            lockop_ff  <= nxt_lockop;
            acking_ff  <= nxt_acking;
            drive_ff   <= nxt_drive;
            sda_out_ff <= nxt_sda_out;
        end
    end

    // nonvolatile cells: no reset term, so the lock survives reset
    always_ff @(posedge i_clk) begin
        if (lock_set) begin
            lock_ff <= 1'b1;
        end
        if (wr_en && idsel_ff && !addr_ff[IDPAGE_OFS_HI]) begin
            idmem_ff[addr_ff[IDPAGE_AW-1:0]] <= shift_ff;
        end
        if (wr_en && !idsel_ff) begin
            mem_ff[addr_ff] <= shift_ff;
        end
    end

    assign o_sda           = sda_out_ff;
    assign o_sda_oe        = drive_ff;
    assign o_idpage_locked = lock_ff;
endmodule : eeprom_rd_slave
`default_nettype wire

// [rd_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module rd_monitor (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_scl,
    input  wire logic i_sda,
    input  wire logic o_sda,
    input  wire logic o_sda_oe,
    input  wire logic o_idpage_locked
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    AST_DRIVE_LOW: assert property (o_sda_oe |-> !o_sda)
        else $error("data pin driven to one");
    AST_OE_AFTER_FALL: assert property ($changed(o_sda_oe) |->
        !$past(i_scl, 2) && !$past(i_scl, 3)) else $error("late data move");
    AST_OE_STEADY_HIGH: assert property (i_scl [*3] |->
        $stable(o_sda_oe)) else $error("data moved while clock high");
    AST_LOCK_STICKY: assert property (o_idpage_locked |=>
        o_idpage_locked) else $error("lock cleared");
    AST_RESET_QUIET: assert property (
        $fell(i_sys_rst) |-> !o_sda_oe) else $error("driving out of reset");
    AST_START_QUIET: assert property (
        i_scl && $past(i_scl) && $fell(i_sda) |=> !o_sda_oe [*8])
        else $error("drive too soon after start");
    AST_STOP_QUIET: assert property (
        i_scl && $past(i_scl) && $rose(i_sda) |=> !o_sda_oe [*8])
        else $error("drive after stop");
    AST_OE_HOLD: assert property ($rose(o_sda_oe) |=>
        o_sda_oe [*3]) else $error("drive too short");
endmodule : rd_monitor
`default_nettype wire

// [bus_ctl.sv]
`timescale 1ns/10ps
`default_nettype none
// two-wire controller: clock 5 cycles low, 3 high
module bus_ctl (
    input  wire logic i_clk,
    input  wire logic i_sda_wire,
    output logic      o_scl,
    output logic      o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic step(input logic c, input logic b, input int n);
        @(posedge i_clk);
        o_scl <= c;
        o_sda <= b;
        repeat (n - 1) @(posedge i_clk);
    endtask : step
    // data moves 3 cycles after the fall, on the same clock edge as the slave's late release
    task automatic bit_io(input logic b, output logic s);
        step(1'b0, b, 2);
        step(1'b1, b, 3);
        s = i_sda_wire;
        step(1'b0, b, 3);
    endtask : bit_io
    task automatic start();
        step(1'b0, 1'b1, 3);
        step(1'b1, 1'b1, 3);
        step(1'b1, 1'b0, 3);
        step(1'b0, 1'b0, 3);
    endtask : start
    task automatic stop();
        step(1'b0, 1'b0, 3);
        step(1'b1, 1'b0, 3);
        step(1'b1, 1'b1, 3);
    endtask : stop
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(v[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : wbyte
    task automatic rbyte(input logic more, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(!more, s);
    endtask : rbyte
endmodule : bus_ctl
`default_nettype wire

// [eeprom_rd_slave_test.sv]
`timescale 1ns/10ps
`default_nettype none
module eeprom_rd_slave_test;
    import eeprom_rd_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [2:0]  cs = 3'h0;
    logic        scl, sda, sda_w, o_sda, o_sda_oe, locked_o, k;
    logic [31:0] seed = 32'h0000F736;
    logic [7:0]  d;
    int          mem[ARRAY_BYTES];
    int          idp[32];
    int          cur, base, err_total, comparisons;
    bit          locked;
    // open drain with pull-up: any party pulling low wins
    assign sda_w = sda & (o_sda_oe ? o_sda : 1'b1);
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    eeprom_rd_slave eeprom_rd_slave_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_scl(scl), .i_sda(sda_w), .i_chip_select_inputs(cs), .o_sda(o_sda),
        .o_sda_oe(o_sda_oe), .o_idpage_locked(locked_o));
    bus_ctl bus_ctl_inst (.i_clk(i_clk), .i_sda_wire(sda_w), .o_scl(scl),
        .o_sda(sda));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic results();
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [15:0] e, g);
        comparisons++;
        if (e !== g) begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk
    task automatic dev(input logic [3:0] t, input logic [2:0] c,
                       input logic rw, input logic e);
        bus_ctl_inst.start();
        bus_ctl_inst.wbyte({t, c, rw}, k);
        chk("dev ack", e, k);
    endtask : dev
    task automatic open_at(input logic [3:0] t, input logic [15:0] a);
        dev(t, cs, 1'b0, 1'b1);
        bus_ctl_inst.wbyte(a[15:8], k);
        chk("hi ack", 1, k);
        bus_ctl_inst.wbyte(a[7:0], k);
        chk("lo ack", 1, k);
    endtask : open_at
    task automatic wr(input logic [3:0] t, input logic [15:0] a, input int n);
        logic e;
        open_at(t, a);
        for (int i = 0; i < n; i++) begin
            d = 8'(rnd());
            e = t == TYPE_ARRAY || !locked;
            bus_ctl_inst.wbyte(d, k);
            chk("data ack", e, k);
            if (e && t == TYPE_ARRAY) mem[(a + i) % ARRAY_BYTES] = d;
            else if (e) idp[(a + i) % IDPAGE_BYTES] = d;
        end
        bus_ctl_inst.stop();
        cur = (a + n) % ARRAY_BYTES;
    endtask : wr
    task automatic rd(input logic [3:0] t, input logic [15:0] a, input int n,
                      input bit here);
        int p, x;
        p = here ? cur : a;
        if (!here) open_at(t, a);
        dev(t, cs, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            bus_ctl_inst.rbyte(i < n - 1, d);
            x = t == TYPE_ARRAY ? mem[p % ARRAY_BYTES] : idp[p % 32];
            chk("data", 16'(x), d);
            p++;
        end
        bus_ctl_inst.stop();
        cur = p % ARRAY_BYTES;
    endtask : rd
    task automatic lock(input logic [15:0] a, input logic [7:0] v);
        open_at(TYPE_IDPAGE, a);
        bus_ctl_inst.wbyte(v, k);
        chk("lock ack", 1, k);
        bus_ctl_inst.stop();
        locked |= v[LOCK_DATA_BIT];
        repeat (4) @(posedge i_clk);
        chk("locked", locked, locked_o);
    endtask : lock
    initial begin
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        cs <= 3'(rnd());
        repeat (4) @(posedge i_clk);
        base = rnd() & 32'h00001FF0;
        wr(TYPE_ARRAY, 16'(base), 4);
        wr(TYPE_ARRAY, 16'h1FFF, 1);
        wr(TYPE_ARRAY, 16'h0000, 2);
        rd(TYPE_ARRAY, 16'(base), 4, 0);
        rd(TYPE_ARRAY, 16'h1FFF, 2, 0);
        rd(TYPE_ARRAY, 16'h0000, 1, 1);
        for (int i = 0; i < 2; i++) begin
            dev(i ? 4'h5 : TYPE_ARRAY, cs ^ 3'(1 - i), 1, 0);
            bus_ctl_inst.stop();
        end
        wr(TYPE_IDPAGE, 16'hFBC5, 3);
        rd(TYPE_IDPAGE, 16'h3A05, 3, 0);
        lock(16'hC7FF, 8'hFD);
        lock(16'h0400, 8'h02);
        wr(TYPE_IDPAGE, 16'h0005, 1);
        rd(TYPE_IDPAGE, 16'h0005, 3, 0);
        i_sys_rst <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk("locked", 1, locked_o);
        rd(TYPE_ARRAY, 16'(base), 2, 0);
        results();
    end
    // the run needs some 5600 cycles
    initial begin
        repeat (30000) @(posedge i_clk);
        err_total++;
        results();
    end
endmodule : eeprom_rd_slave_test
bind eeprom_rd_slave rd_monitor rd_monitor_inst (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .o_idpage_locked(o_idpage_locked));
`default_nettype wire
